// ==== design/fifo_pkg.sv ====
package fifo_pkg;

    // word and storage geometry
    localparam int DATA_W     = 9;
    localparam int ADDR_W     = 16;
    localparam int PTR_W      = 17;
    localparam int OFF_W      = 16;
    localparam int OFF_HIGH_W = 7;

    // count that marks a full buffer (65536 words)
    localparam logic [PTR_W-1:0] DEPTH_COUNT = 17'h1_0000;
    localparam logic [PTR_W-1:0] PTR_RESET   = 17'h0_0000;

    // programmable offset registers, default offset of seven words
    localparam logic [DATA_W-1:0] OFF_LOW_RESET  = 9'h007;
    localparam logic [DATA_W-1:0] OFF_HIGH_RESET = 9'h000;

    // offset register sequence positions
    localparam logic [1:0] SEL_EMPTY_LOW  = 2'h0;
    localparam logic [1:0] SEL_EMPTY_HIGH = 2'h1;
    localparam logic [1:0] SEL_FULL_LOW   = 2'h2;
    localparam logic [1:0] SEL_FULL_HIGH  = 2'h3;

    // flag levels at reset
    localparam logic EMPTY_RESET        = 1'b0;
    localparam logic ALMOST_EMPTY_RESET = 1'b0;
    localparam logic FULL_RESET         = 1'b1;
    localparam logic ALMOST_FULL_RESET  = 1'b1;
    localparam logic EXP_OUT_RESET      = 1'b1;

    // operating mode chosen at reset by the expansion/load pin
    typedef enum logic {
        MODE_PROG,
        MODE_DEPTH
    } mode_t;

    // one sample of all pin inputs, carried through the synchroniser
    typedef struct packed {
        logic              write_clk;
        logic              read_clk;
        logic              write_en_n;
        logic              read_en_n;
        logic              load_n;
        logic              oe_n;
        logic              retransmit;
        logic [DATA_W-1:0] write_data;
    } pin_sample_t;

endpackage

// ==== design/fifo_core.sv ====
`timescale 1ns/1ps

// How it works
// (RULE1) reset empties buffer, empty flag low
// (RULE2) outputs low after reset when enabled
// (RULE3) no reads or writes during reset
// (RULE4) load pin at reset selects mode
// (RULE5) free-running clocks during reset harmless
// (RULE6) write edge stores word when not full
// (RULE7) read edge presents next word when nonempty
// (RULE8) output enable low drives data, else off
// (RULE9) cascaded: only read-enabled device drives
// (RULE10) full ignores writes, empty ignores reads
// (RULE11) empty buffer keeps last read word
// (RULE12) load pin becomes offset load enable
// (RULE13) offset writes cycle four registers, wrap
// (RULE14) offset sequence pointer kept across loads
// (RULE15) offset reads follow same sequence
// (RULE16) avoid simultaneous offset read and write
// (RULE17) almost-empty low at count up to n
// (RULE18) almost-full low at count depth minus m
// (RULE19) first word readable after empty rises
// (RULE20) almost-empty may lag one read edge
// (RULE21) almost flags settle one edge after rewind
// (RULE22) offsets default to seven words
// (RULE23) retransmit pulse rewinds read pointer
// (RULE24) empty on read edges, full on write
// (RULE25) pointers wrap, count from their difference
module fifo_core
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        write_clk_i,
    input  wire logic                        read_clk_i,
    input  wire logic                        write_enable_n_i,
    input  wire logic                        read_enable_n_i,
    input  wire logic                        output_enable_n_i,
    input  wire logic                        expansion_in_or_load_i,
    input  wire logic                        retransmit_i,
    input  wire logic [fifo_pkg::DATA_W-1:0] write_data_i,
    output logic      [fifo_pkg::DATA_W-1:0] read_data_o,
    output logic                             read_data_oe_o,
    output logic                             empty_flag_n_o,
    output logic                             full_flag_n_o,
    output logic                             almost_empty_flag_n_o,
    output logic                             almost_full_flag_n_o,
    output logic                             expansion_out_o
);
    import fifo_pkg::*;

    // pointer advance, wraps modulo twice the depth
    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        ptr_inc = PTR_W'(p + 1'b1);
    endfunction

    pin_sample_t                raw;
    pin_sample_t                s1;
    pin_sample_t                s2;
    pin_sample_t                s3;
    logic                       wclk_level;
    logic                       rclk_level;
    logic                       rt_level;
    logic                       mode_pending;
    mode_t                      mode;
    logic [PTR_W-1:0]           wr_ptr;
    logic [PTR_W-1:0]           rd_ptr;
    logic [1:0]                 off_sel;
    logic [DATA_W-1:0]          empty_offset_low;
    logic [DATA_W-1:0]          empty_offset_high;
    logic [DATA_W-1:0]          full_offset_low;
    logic [DATA_W-1:0]          full_offset_high;
    logic [DATA_W-1:0]          mem [0:(1<<ADDR_W)-1];

    // pin bundle entering the synchroniser
    assign raw = {write_clk_i, read_clk_i, write_enable_n_i, read_enable_n_i,
                  expansion_in_or_load_i, output_enable_n_i, retransmit_i,
                  write_data_i};

    // three-stage synchroniser, left unreset so the strap is seen in reset
    always_ff @(posedge clk_i)
    begin
        s1 <= raw;
        s2 <= s1;
        s3 <= s2;
    end

    // edge detection on stages two and three agreeing
    logic w_agree;
    logic r_agree;
    logic t_agree;
    logic w_rise;
    logic r_rise;
    logic rt_rise;
    assign w_agree = (s2.write_clk == s3.write_clk);
    assign r_agree = (s2.read_clk == s3.read_clk);
    assign t_agree = (s2.retransmit == s3.retransmit);
    assign w_rise  = w_agree & s3.write_clk & ~wclk_level;
    assign r_rise  = r_agree & s3.read_clk & ~rclk_level;
    assign rt_rise = t_agree & s3.retransmit & ~rt_level;

    // settled levels of the sampled clocks and retransmit
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wclk_level <= 1'b0;
            rclk_level <= 1'b0;
            rt_level   <= 1'b0;
        end
        else
        begin
            if (w_agree) wclk_level <= s3.write_clk;
            if (r_agree) rclk_level <= s3.read_clk;
            if (t_agree) rt_level   <= s3.retransmit;
        end
    end

    // mode strap caught in the first cycle after reset release
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_pending <= 1'b1;
            mode         <= MODE_PROG;
        end
        else if (mode_pending)
        begin
            mode_pending <= 1'b0;
            mode         <= s3.load_n ? MODE_DEPTH : MODE_PROG; // RULE4
        end
    end

    // request decode; nothing is taken until the strap is caught
    logic load_active;
    logic wr_req;
    logic rd_req;
    logic do_write;
    logic do_read;
    logic off_wr;
    logic off_rd;
    logic rt_go;
    assign load_active = (mode == MODE_PROG) & ~s3.load_n; // RULE12
    assign wr_req   = w_rise & ~s3.write_en_n & ~mode_pending; // RULE5
    assign rd_req   = r_rise & ~s3.read_en_n & ~mode_pending;
    assign do_write = wr_req & ~load_active & full_flag_n_o; // RULE6 RULE10
    assign do_read  = rd_req & ~load_active & empty_flag_n_o; // RULE7 RULE10
    assign off_wr   = wr_req & load_active;
    assign off_rd   = rd_req & load_active;
    assign rt_go    = rt_rise & (mode == MODE_PROG) & ~mode_pending;

    // next pointers and the unread word count
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [PTR_W-1:0] next_count;
    assign next_wr_ptr = do_write ? ptr_inc(wr_ptr) : wr_ptr; // RULE25
    assign next_rd_ptr = rt_go ? PTR_RESET :                 // RULE23
                         (do_read ? ptr_inc(rd_ptr) : rd_ptr);
    assign next_count  = PTR_W'(next_wr_ptr - next_rd_ptr); // RULE25

    // offsets assembled from their low and high registers
    logic [OFF_W-1:0] empty_offset;
    logic [OFF_W-1:0] full_offset;
    logic [PTR_W-1:0] full_level;
    assign empty_offset = {empty_offset_high[OFF_HIGH_W-1:0], empty_offset_low};
    assign full_offset  = {full_offset_high[OFF_HIGH_W-1:0], full_offset_low};
    assign full_level   = PTR_W'(DEPTH_COUNT - {1'b0, full_offset});

    // offset register selected by the sequence pointer
    logic [DATA_W-1:0] off_read_value;
    assign off_read_value = (off_sel == SEL_EMPTY_LOW)  ? empty_offset_low  :
                            (off_sel == SEL_EMPTY_HIGH) ? empty_offset_high :
                            (off_sel == SEL_FULL_LOW)   ? full_offset_low   :
                                                          full_offset_high; // RULE15

    // pointers; the read pointer moves only with valid reads or rewind
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= PTR_RESET; // RULE1
            rd_ptr <= PTR_RESET;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage array, no reset needed on the words themselves
    always_ff @(posedge clk_i)
    begin
        if (do_write)
            mem[wr_ptr[ADDR_W-1:0]] <= s3.write_data; // RULE6
    end

    // offset registers and their shared sequence pointer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            off_sel           <= SEL_EMPTY_LOW;
            empty_offset_low  <= OFF_LOW_RESET;  // RULE22
            empty_offset_high <= OFF_HIGH_RESET;
            full_offset_low   <= OFF_LOW_RESET;  // RULE22
            full_offset_high  <= OFF_HIGH_RESET;
        end
        else
        begin
            if (off_wr)
            begin
                unique case (off_sel) // RULE13
                    SEL_EMPTY_LOW:  empty_offset_low  <= s3.write_data;
                    SEL_EMPTY_HIGH: empty_offset_high <= s3.write_data;
                    SEL_FULL_LOW:   full_offset_low   <= s3.write_data;
                    SEL_FULL_HIGH:  full_offset_high  <= s3.write_data;
                endcase
            end
            // a combined read and write steps once (RULE16 forbids it)
            if (off_wr | off_rd)
                off_sel <= 2'(off_sel + 1'b1); // RULE13 RULE14
        end
    end

    // output register; holds the last word when a read is refused
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            read_data_o <= '0; // RULE2
        else if (off_rd)
            read_data_o <= off_read_value; // RULE15
        else if (do_read)
            read_data_o <= mem[rd_ptr[ADDR_W-1:0]]; // RULE7 RULE11
    end

    // output drive enable, only on the read-enabled device when cascaded
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            read_data_oe_o <= 1'b0;
        else
            read_data_oe_o <= ~s3.oe_n & // RULE8 RULE2
                              ((mode == MODE_PROG) | ~s3.read_en_n); // RULE9
    end

    // read-side flags, updated only on read edges; a rewind shows at the next one
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            empty_flag_n_o        <= EMPTY_RESET;        // RULE1
            almost_empty_flag_n_o <= ALMOST_EMPTY_RESET;
        end
        else if (r_rise)
        begin
            // a write landing before or with this edge is already counted
            empty_flag_n_o        <= (next_count != PTR_RESET); // RULE24 RULE19
            almost_empty_flag_n_o <=
                (next_count > {1'b0, empty_offset}); // RULE17 RULE20 RULE21
        end
    end

    // write-side flags, updated only on write edges
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            full_flag_n_o        <= FULL_RESET;
            almost_full_flag_n_o <= ALMOST_FULL_RESET;
        end
        else if (w_rise)
        begin
            full_flag_n_o        <= (next_count != DEPTH_COUNT); // RULE24
            almost_full_flag_n_o <= (next_count < full_level); // RULE18 RULE21
        end
    end

    // expansion token output, held inactive; token passing is not built
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            expansion_out_o <= EXP_OUT_RESET;
        else
            expansion_out_o <= EXP_OUT_RESET;
    end

endmodule

// ==== bench/fifo_core_props.sv ====
`timescale 1ns/1ps

module fifo_core_props
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        read_clk_i,
    input  wire logic                        output_enable_n_i,
    input  wire logic                        expansion_in_or_load_i,
    input  wire logic [fifo_pkg::DATA_W-1:0] read_data_o,
    input  wire logic                        read_data_oe_o,
    input  wire logic                        empty_flag_n_o,
    input  wire logic                        almost_empty_flag_n_o,
    input  wire logic                        full_flag_n_o,
    input  wire logic                        almost_full_flag_n_o
);
    import fifo_pkg::*;
    logic       rd_q;
    logic [3:0] rd_age;
    logic [3:0] next_rd_age;
    // cycles since the read pin clock last rose, saturating at 15
    assign next_rd_age = (read_clk_i && !rd_q) ? 4'h0
                       : rd_age + {3'h0, rd_age != 4'hf};
    always_ff @(posedge clk_i)
        rd_q <= read_clk_i;
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            rd_age <= 4'hf;
        else
            rd_age <= next_rd_age;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // building blocks of the multi-cycle checks
    sequence s_oe_low;
        (!output_enable_n_i) [*6];
    endsequence
    sequence s_oe_high;
        output_enable_n_i [*6];
    endsequence
    sequence s_rd_recent;
        rd_age inside {[4'h1:4'h6]};
    endsequence
    sequence s_idle_empty;
        (!empty_flag_n_o && expansion_in_or_load_i) [*8];
    endsequence
    property p_reset_vals;
        disable iff (1'b0)
        rst_i |-> !empty_flag_n_o && !almost_empty_flag_n_o && full_flag_n_o
            && almost_full_flag_n_o && !read_data_oe_o
            && read_data_o == 9'h000;
    endproperty
    property p_oe_on;
        s_oe_low |-> read_data_oe_o;
    endproperty
    property p_oe_off;
        s_oe_high |-> !read_data_oe_o;
    endproperty
    property p_empty_rd;
        $changed(empty_flag_n_o) |-> s_rd_recent;
    endproperty
    property p_ae_rd;
        $changed(almost_empty_flag_n_o) |-> s_rd_recent;
    endproperty
    property p_data_rd;
        $changed(read_data_o) |-> s_rd_recent;
    endproperty
    property p_ae_empty;
        !empty_flag_n_o |-> !almost_empty_flag_n_o;
    endproperty
    property p_hold;
        s_idle_empty |=> $stable(read_data_o);
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs wrong during reset");
    a_oe_on: assert property (p_oe_on)
        else $error("data pins not driven");
    a_oe_off: assert property (p_oe_off)
        else $error("data pins driven while disabled");
    a_empty_rd: assert property (p_empty_rd)
        else $error("empty flag moved off a read edge");
    a_ae_rd: assert property (p_ae_rd)
        else $error("almost empty moved off a read edge");
    a_data_rd: assert property (p_data_rd)
        else $error("read data moved off a read edge");
    a_ae_empty: assert property (p_ae_empty)
        else $error("almost empty high while empty");
    a_hold: assert property (p_hold)
        else $error("read data changed while empty");
endmodule

bind fifo_core fifo_core_props i_props
(
    .clk_i(clk_i), .rst_i(rst_i), .read_clk_i(read_clk_i),
    .output_enable_n_i(output_enable_n_i), .read_data_o(read_data_o),
    .expansion_in_or_load_i(expansion_in_or_load_i),
    .read_data_oe_o(read_data_oe_o), .empty_flag_n_o(empty_flag_n_o),
    .almost_empty_flag_n_o(almost_empty_flag_n_o),
    .full_flag_n_o(full_flag_n_o), .almost_full_flag_n_o(almost_full_flag_n_o)
);

// ==== bench/fifo_partner.sv ====
`timescale 1ns/1ps

module fifo_partner
(
    input  wire logic                        clk_i,
    output logic                             write_clk_o,
    output logic                             read_clk_o,
    output logic                             write_enable_n_o,
    output logic                             read_enable_n_o,
    output logic      [fifo_pkg::DATA_W-1:0] write_data_o
);
    import fifo_pkg::*;
    // pins rest with clocks still and enables off
    initial
    begin
        write_clk_o = 1'b0;
        read_clk_o = 1'b0;
        write_enable_n_o = 1'b1;
        read_enable_n_o = 1'b1;
        write_data_o = 9'h1ff;
    end
    // one pin clock period, 4 cycles high and 4 low, one side at a time
    task automatic pulse(input logic rd, input logic en_n,
                         input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        #1 write_enable_n_o = rd | en_n;
        read_enable_n_o = !rd | en_n;
        write_data_o = d;
        @(posedge clk_i);
        #1 write_clk_o = !rd;
        read_clk_o = rd;
        repeat (4) @(posedge clk_i);
        #1 write_clk_o = 1'b0;
        read_clk_o = 1'b0;
        repeat (4) @(posedge clk_i);
        #1 write_enable_n_o = 1'b1;
        read_enable_n_o = 1'b1;
        write_data_o = ~d; // released data shows its inverse
    endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps

module testbench;
    import fifo_pkg::*;
    logic              clk_i;
    logic              rst_i;
    logic              oe_n;
    logic              load_n;
    logic              retransmit;
    logic              wclk;
    logic              rclk;
    logic              wen_n;
    logic              ren_n;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              rdata_oe;
    logic              empty_n;
    logic              full_n;
    logic              ae_n;
    logic              af_n;
    logic              xo;
    int                n_errors = 0;
    int                total_checks = 0;
    fifo_core i_fifo_core
    (
        .clk_i(clk_i), .rst_i(rst_i), .write_clk_i(wclk), .read_clk_i(rclk),
        .write_enable_n_i(wen_n), .read_enable_n_i(ren_n),
        .output_enable_n_i(oe_n), .expansion_in_or_load_i(load_n),
        .retransmit_i(retransmit), .write_data_i(wdata), .read_data_o(rdata),
        .read_data_oe_o(rdata_oe), .empty_flag_n_o(empty_n),
        .full_flag_n_o(full_n), .almost_empty_flag_n_o(ae_n),
        .almost_full_flag_n_o(af_n), .expansion_out_o(xo)
    );
    fifo_partner i_fifo_partner
    (
        .clk_i(clk_i), .write_clk_o(wclk), .read_clk_o(rclk),
        .write_enable_n_o(wen_n), .read_enable_n_o(ren_n), .write_data_o(wdata)
    );
    // 20 MHz system clock
    always #25 clk_i = ~clk_i;
    // comparison, counting and verdict helpers
    task automatic chk_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_word(input string n, input logic [DATA_W-1:0] e,
                            input logic [DATA_W-1:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // bus steps: idle cycles, one pin write, one pin read
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [DATA_W-1:0] d);
        i_fifo_partner.pulse(1'b0, 1'b0, d);
    endtask
    task automatic rd(input logic en_n);
        i_fifo_partner.pulse(1'b1, en_n, 9'h000);
    endtask
    function automatic logic [DATA_W-1:0] word(input int i);
        return 9'h0a5 ^ DATA_W'(i * 61);
    endfunction
    // reset levels, then output enable drives and releases the pins
    task automatic t_reset_out;
        chk_bit("empty", 1'b0, empty_n);
        chk_bit("almost_empty", 1'b0, ae_n);
        chk_bit("full", 1'b1, full_n);
        chk_bit("almost_full", 1'b1, af_n);
        chk_bit("oe", 1'b0, rdata_oe);
        chk_bit("expansion_out", 1'b1, xo);
        rst_i = 1'b0;
        wait_cyc(1);
        load_n = 1'b1;
        oe_n = 1'b0;
        wait_cyc(6);
        chk_bit("oe", 1'b1, rdata_oe);
        chk_word("data", 9'h000, rdata);
        oe_n = 1'b1;
        wait_cyc(6);
        chk_bit("oe", 1'b0, rdata_oe);
        oe_n = 1'b0;
    endtask
    // a read on an empty buffer is ignored
    task automatic t_empty_read;
        rd(1'b0);
        chk_bit("empty", 1'b0, empty_n);
        chk_word("data", 9'h000, rdata);
    endtask
    // eight words in, flags at the default offset, eight words out
    task automatic t_stream;
        for (int i = 0; i < 8; i++)
            wr(word(i));
        chk_bit("empty", 1'b0, empty_n);
        rd(1'b1);
        chk_bit("empty", 1'b1, empty_n);
        chk_bit("almost_empty", 1'b1, ae_n);
        for (int i = 0; i < 8; i++)
        begin
            rd(1'b0);
            chk_word("data", word(i), rdata);
            chk_bit("almost_empty", 1'b0, ae_n);
        end
        rd(1'b0);
        chk_bit("empty", 1'b0, empty_n);
        chk_word("data", word(7), rdata);
    endtask
    // five offset writes wrap, n becomes 3, m becomes 65532 (level 4)
    task automatic t_offsets;
        logic [DATA_W-1:0] exp_off [4] = '{9'h000, 9'h1fc, 9'h07f, 9'h003};
        load_n = 1'b0;
        wr(9'h002);
        wr(9'h000);
        wr(9'h1fc);
        wr(9'h07f);
        wr(9'h003);
        load_n = 1'b1;
        rd(1'b1);
        chk_bit("empty", 1'b0, empty_n);
        load_n = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rd(1'b0);
            chk_word("offset", exp_off[i], rdata);
        end
        load_n = 1'b1;
        for (int i = 8; i < 12; i++)
            wr(word(i));
        chk_bit("almost_full", 1'b0, af_n);
        rd(1'b1);
        chk_bit("almost_empty", 1'b1, ae_n);
        rd(1'b0);
        chk_word("data", word(8), rdata);
        chk_bit("almost_empty", 1'b0, ae_n);
    endtask
    // retransmit rewinds to the first word ever stored
    task automatic t_retransmit;
        retransmit = 1'b1;
        wait_cyc(6);
        retransmit = 1'b0;
        wait_cyc(6);
        rd(1'b1);
        chk_bit("almost_empty", 1'b1, ae_n);
        rd(1'b0);
        chk_word("data", word(0), rdata);
    endtask
    // main sequence
    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        oe_n = 1'b1;
        load_n = 1'b0;
        retransmit = 1'b0;
        wait_cyc(16);
        t_reset_out();
        t_empty_read();
        t_stream();
        t_offsets();
        t_retransmit();
        wrap_up();
    end
    // the run needs about 410 cycles; cut a hang at 5000
    initial
    begin
        #(50 * 5000);
        n_errors++;
        wrap_up();
    end
endmodule
